/* pkg/trcfg_pkg.sv */
package trcfg_pkg;
  localparam logic [2:0] TRCFG_MODE_PMA = 3'h0;
  localparam logic [2:0] TRCFG_MODE_CHAN = 3'h1;
  localparam logic [2:0] TRCFG_MODE_PLL = 3'h2;
  localparam int TRCFG_DETECT_CYC = 2;
  localparam int TRCFG_ERR_CYC = 2;
  localparam int TRCFG_OC_SIM_CYC = 16;
  localparam int TRCFG_CLK_MHZ = 40;
  localparam int TRCFG_LOCK_WAIT_NS = 4000;
  localparam int TRCFG_LOCK_WAIT_CYC =
    (TRCFG_LOCK_WAIT_NS * TRCFG_CLK_MHZ + 999) / 1000;
  localparam int TRCFG_OP_CYC = 8;
  localparam int TRCFG_TIMEOUT_CYC = 64;
  localparam logic [3:0] TRCFG_OFF_CTRL = 4'h0;
  localparam logic [3:0] TRCFG_OFF_STAT = 4'h1;
  localparam logic [3:0] TRCFG_OFF_IRQ_STAT = 4'h2;
  localparam logic [3:0] TRCFG_OFF_IRQ_CLR = 4'h3;
  localparam logic [3:0] TRCFG_OFF_IRQ_EN = 4'h4;
  localparam logic [3:0] TRCFG_OFF_NCHAN = 4'h5;
  localparam int TRCFG_CTRL_GO = 0;
  localparam int TRCFG_IRQ_DONE = 0;
  localparam int TRCFG_IRQ_ERR = 1;
  localparam int TRCFG_IRQ_W = 2;
endpackage

/* pkg/trcfg_if.sv */
`timescale 1ns/1ps
interface trcfg_if;
  logic read;
  logic write_all;
  logic [2:0] mode_sel;
  logic busy;
  logic error;
  logic op_done;
  logic offset_cancel;
  logic rx_freqlocked;
  logic pll_reconfig_done;
  logic tx_digitalreset;
  logic rx_digitalreset;
  logic rx_analogreset;
  logic powerdown;
  modport ctrl (input read, input write_all, input mode_sel,
    output busy, output error, output op_done, output offset_cancel,
    input rx_freqlocked, input pll_reconfig_done, input tx_digitalreset,
    input rx_digitalreset, input rx_analogreset, input powerdown);
  modport user (output read, output write_all, output mode_sel,
    input busy, input error, input op_done, input offset_cancel,
    input rx_freqlocked, input pll_reconfig_done,
    output tx_digitalreset, output rx_digitalreset,
    output rx_analogreset, output powerdown);
endinterface

/* rtl/trcfg_ctrl.sv */
`timescale 1ns/1ps
module trcfg_ctrl
  import trcfg_pkg::*;
#(
  parameter bit CHECK_ILLEGAL = 1'b1,
  parameter bit SELF_RECOVER = 1'b1,
  parameter bit PMA_OUT_EN = 1'b0,
  parameter bit PMA_IN_EN = 1'b0,
  parameter int OP_CYC = TRCFG_OP_CYC,
  parameter int TIMEOUT_CYC = TRCFG_TIMEOUT_CYC,
  parameter int OC_CYC = TRCFG_OC_SIM_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic stall,
  trcfg_if.ctrl lnk
);
  typedef enum logic [3:0] {
    TRCFG_S_OC = 4'h1,
    TRCFG_S_IDLE = 4'h2,
    TRCFG_S_OP = 4'h4,
    TRCFG_S_ERR = 4'h8
  } trcfg_state_t;

  trcfg_state_t state_ff, nxt_state;
  logic [7:0] cnt_ff, nxt_cnt;
  logic busy_ff, err_ff, done_ff, oc_ff;

  wire req = lnk.read | lnk.write_all;
  wire ill_pma_rd = (lnk.mode_sel == TRCFG_MODE_PMA) & lnk.read
    & !PMA_OUT_EN;
  wire ill_pma_wr = (lnk.mode_sel == TRCFG_MODE_PMA) & lnk.write_all
    & !PMA_IN_EN;
  wire ill_chan_rd = (lnk.mode_sel == TRCFG_MODE_CHAN) & lnk.read;
  // pma values themselves are never range checked
  wire illegal = CHECK_ILLEGAL & (ill_pma_rd | ill_pma_wr | ill_chan_rd);
  wire op_end = (cnt_ff == 8'(OP_CYC - 1)) & !stall;
  wire op_over = SELF_RECOVER & (cnt_ff == 8'(TIMEOUT_CYC - 1));
  wire has_err = CHECK_ILLEGAL | SELF_RECOVER;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 8'h01;
    case (state_ff)
      TRCFG_S_OC: begin
        if (cnt_ff == 8'(OC_CYC - 1)) begin
          nxt_state = TRCFG_S_IDLE;
          nxt_cnt = 8'h00;
        end
      end
      TRCFG_S_IDLE: begin
        nxt_cnt = 8'h00;
        if (req && !lnk.powerdown) begin
          nxt_state = illegal ? TRCFG_S_ERR : TRCFG_S_OP;
        end
      end
      TRCFG_S_OP: begin
        if (op_over) begin
          nxt_state = TRCFG_S_ERR;
          nxt_cnt = 8'h00;
        end else if (op_end) begin
          nxt_state = TRCFG_S_IDLE;
          nxt_cnt = 8'h00;
        end else if (stall) begin
          nxt_cnt = cnt_ff + 8'h01;
        end
      end
      TRCFG_S_ERR: begin
        if (cnt_ff == 8'(TRCFG_ERR_CYC - 1)) begin
          nxt_state = TRCFG_S_IDLE;
          nxt_cnt = 8'h00;
        end
      end
      default: begin
        nxt_state = TRCFG_S_IDLE;
        nxt_cnt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= TRCFG_S_OC;
      cnt_ff <= 8'h00;
      busy_ff <= 1'b1;
      err_ff <= 1'b0;
      done_ff <= 1'b0;
      oc_ff <= 1'b1;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      cnt_ff <= lnk.powerdown && state_ff == TRCFG_S_OC ? 8'h00 : nxt_cnt;
      busy_ff <= nxt_state == TRCFG_S_OP || nxt_state == TRCFG_S_OC;
      err_ff <= has_err && nxt_state == TRCFG_S_ERR;
      done_ff <= state_ff == TRCFG_S_OP && nxt_state == TRCFG_S_IDLE;
      oc_ff <= nxt_state == TRCFG_S_OC;
    end
  end

  assign lnk.busy = busy_ff;
  assign lnk.error = err_ff;
  assign lnk.op_done = done_ff;
  assign lnk.offset_cancel = oc_ff;
endmodule

/* rtl/trcfg_user.sv */
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module trcfg_user
  import trcfg_pkg::*;
#(
  parameter int LOCK_WAIT_CYC = TRCFG_LOCK_WAIT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  trcfg_if.user lnk
);
  typedef enum logic [6:0] {
    TRCFG_U_IDLE = 7'h01,
    TRCFG_U_PLL = 7'h02,
    TRCFG_U_CHAN = 7'h04,
    TRCFG_U_CWAIT = 7'h08,
    TRCFG_U_LOCK = 7'h10,
    TRCFG_U_WAIT = 7'h20,
    TRCFG_U_ERR = 7'h40
  } trcfg_ustate_t;

  trcfg_ustate_t st_ff, nxt_st;
  logic [7:0] nchan_ff, chan_ff;
  logic [15:0] cnt_ff;
  logic [TRCFG_IRQ_W-1:0] stat_ff, en_ff;
  logic [31:0] rdata_ff;
  logic irq_ff, rd_ff, wr_ff, tx_ff, rxa_ff, rxd_ff;
  logic evt_done, evt_err;

  wire go = clk_en & wr & (addr == TRCFG_OFF_CTRL) & wdata[TRCFG_CTRL_GO];
  wire in_oc = lnk.offset_cancel;
  wire [31:0] rsel = (addr == TRCFG_OFF_STAT) ?
      {25'h0, st_ff != TRCFG_U_IDLE, rxd_ff, rxa_ff, tx_ff,
       lnk.rx_freqlocked, lnk.error, lnk.busy} :
    (addr == TRCFG_OFF_IRQ_STAT) ? {30'h0, stat_ff} :
    (addr == TRCFG_OFF_IRQ_EN) ? {30'h0, en_ff} :
    (addr == TRCFG_OFF_NCHAN) ? {24'h0, nchan_ff} : 32'h0;

  always_comb begin
    nxt_st = st_ff;
    evt_done = 1'b0;
    evt_err = 1'b0;
    case (st_ff)
      TRCFG_U_IDLE: if (go && !in_oc) nxt_st = TRCFG_U_PLL;
      TRCFG_U_PLL: if (lnk.pll_reconfig_done) nxt_st = TRCFG_U_CHAN;
      TRCFG_U_CHAN: if (!lnk.busy) nxt_st = TRCFG_U_CWAIT;
      TRCFG_U_CWAIT: begin
        if (lnk.error) begin
          nxt_st = TRCFG_U_ERR;
        end else if (lnk.op_done) begin
          nxt_st = (chan_ff + 8'h01 >= nchan_ff) ? TRCFG_U_LOCK
            : TRCFG_U_CHAN;
        end
      end
      TRCFG_U_LOCK: if (lnk.rx_freqlocked) nxt_st = TRCFG_U_WAIT;
      TRCFG_U_WAIT: begin
        if (!lnk.rx_freqlocked) begin
          nxt_st = TRCFG_U_LOCK;
        end else if (cnt_ff >= 16'(LOCK_WAIT_CYC - 1)) begin
          nxt_st = TRCFG_U_IDLE;
          evt_done = 1'b1;
        end
      end
      TRCFG_U_ERR: begin
        nxt_st = TRCFG_U_IDLE;
        evt_err = 1'b1;
      end
      default: nxt_st = TRCFG_U_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= TRCFG_U_IDLE;
      chan_ff <= 8'h00;
      nchan_ff <= 8'h01;
      cnt_ff <= 16'h0000;
      stat_ff <= '0;
      en_ff <= '0;
      rdata_ff <= 32'h0;
      irq_ff <= 1'b0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      tx_ff <= 1'b1;
      rxa_ff <= 1'b1;
      rxd_ff <= 1'b1;
    end else if (clk_en) begin
      st_ff <= nxt_st;
      chan_ff <= st_ff == TRCFG_U_PLL ? 8'h00
        : (st_ff == TRCFG_U_CWAIT && lnk.op_done) ? chan_ff + 8'h01
        : chan_ff;
      cnt_ff <= st_ff == TRCFG_U_WAIT ? cnt_ff + 16'h0001 : 16'h0000;
      if (wr && addr == TRCFG_OFF_NCHAN) nchan_ff <= wdata[7:0];
      if (wr && addr == TRCFG_OFF_IRQ_EN) en_ff <= wdata[TRCFG_IRQ_W-1:0];
      // a new event wins over a clear in the same cycle
      stat_ff <= (stat_ff & ~((wr && addr == TRCFG_OFF_IRQ_CLR) ?
        wdata[TRCFG_IRQ_W-1:0] : '0)) | {evt_err, evt_done};
      irq_ff <= |(stat_ff & en_ff);
      rdata_ff <= rd ? rsel : 32'h0;
      wr_ff <= nxt_st == TRCFG_U_CHAN && st_ff != TRCFG_U_CHAN;
      rd_ff <= 1'b0;
      if (nxt_st == TRCFG_U_PLL) begin
        tx_ff <= 1'b1;
        rxa_ff <= 1'b1;
        rxd_ff <= 1'b1;
      end else if (nxt_st == TRCFG_U_LOCK && st_ff == TRCFG_U_CWAIT) begin
        tx_ff <= 1'b0;
        rxa_ff <= 1'b0;
      end else if (evt_done) begin
        rxd_ff <= 1'b0;
      end else if (evt_err) begin
        tx_ff <= 1'b1;
        rxa_ff <= 1'b1;
      end
    end
  end

  assign rdata = rdata_ff;
  assign irq = irq_ff;
  assign lnk.read = rd_ff;
  assign lnk.write_all = wr_ff;
  assign lnk.mode_sel = TRCFG_MODE_CHAN;
  assign lnk.powerdown = 1'b0;
  assign lnk.tx_digitalreset = tx_ff;
  assign lnk.rx_digitalreset = rxd_ff;
  assign lnk.rx_analogreset = rxa_ff;
endmodule

/* tb/trcfg_properties.sv */
`timescale 1ns/1ps
module trcfg_properties
  import trcfg_pkg::*;
#(
  parameter int LOCK_WAIT_CYC = TRCFG_LOCK_WAIT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write_all,
  input wire logic [2:0] mode_sel,
  input wire logic busy,
  input wire logic error,
  input wire logic offset_cancel,
  input wire logic powerdown,
  input wire logic rx_freqlocked,
  input wire logic tx_digitalreset,
  input wire logic rx_digitalreset,
  input wire logic rx_analogreset
);
  logic [7:0] oc_cnt_ff;
  logic [15:0] lk_cnt_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oc_cnt_ff <= 8'h00;
      lk_cnt_ff <= 16'h0000;
    end else begin
      if (offset_cancel) oc_cnt_ff <= oc_cnt_ff + 8'h01;
      lk_cnt_ff <= rx_freqlocked ? lk_cnt_ff + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_err_pulse;
    error ##1 error ##1 !error;
  endsequence
  sequence s_bad_read;
    !busy && !powerdown && read && mode_sel == TRCFG_MODE_CHAN;
  endsequence
  a_bad_read_err: assert property (s_bad_read |=> s_err_pulse)
    else $error("channel mode read gave no error pulse");
  a_err_two_cyc: assert property ($rose(error) |=> error ##1 !error)
    else $error("error pulse not two cycles");
  a_err_busy_low: assert property (error |-> !busy)
    else $error("busy high during error");
  a_oc_length: assert property ($fell(offset_cancel) |-> oc_cnt_ff == 8'h10)
    else $error("offset cancel length wrong");
  a_pd_oc_low: assert property (offset_cancel |-> !powerdown)
    else $error("power-down during offset cancel");
  a_rxd_lock_wait: assert property ($fell(rx_digitalreset) |->
    lk_cnt_ff >= LOCK_WAIT_CYC)
    else $error("rx logic reset released early");
  a_rxd_last_off: assert property ($fell(rx_digitalreset) |->
    !tx_digitalreset && !rx_analogreset)
    else $error("rx logic reset released first");
  a_resets_in_op: assert property (write_all |->
    tx_digitalreset && rx_digitalreset && rx_analogreset)
    else $error("channel write with resets low");
endmodule

/* tb/transceiver_reconfig_error_and_reset_seq_test.sv */
`timescale 1ns/1ps
module transceiver_reconfig_error_and_reset_seq_test;
  import trcfg_pkg::*;
  logic clk_sys = 1'b0;
  localparam int TB_LOCK_CYC = 4;
  logic rst_n, wr, rd, stall, irq, ce;
  int n;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, d;
  int num_errors = 0;
  int check_count = 0;
  trcfg_if lnk_a();
  trcfg_if lnk_b();
  always #12.5 clk_sys = ~clk_sys;
  trcfg_ctrl i_trcfg_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(1'b1), .stall(1'b0), .lnk(lnk_a));
  trcfg_user #(.LOCK_WAIT_CYC(TB_LOCK_CYC)) i_trcfg_user (.clk_sys(clk_sys),
    .rst_n(rst_n), .clk_en(1'b1), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .lnk(lnk_a));
  trcfg_ctrl i_trcfg_ctrl_b (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(ce), .stall(stall), .lnk(lnk_b));
  trcfg_properties #(.LOCK_WAIT_CYC(TB_LOCK_CYC)) i_trcfg_properties (
    .clk_sys(clk_sys), .rst_n(rst_n), .read(lnk_b.read),
    .write_all(lnk_a.write_all), .mode_sel(lnk_b.mode_sel),
    .busy(lnk_b.busy), .error(lnk_b.error),
    .offset_cancel(lnk_a.offset_cancel), .powerdown(lnk_a.powerdown),
    .rx_freqlocked(lnk_a.rx_freqlocked),
    .tx_digitalreset(lnk_a.tx_digitalreset),
    .rx_digitalreset(lnk_a.rx_digitalreset),
    .rx_analogreset(lnk_a.rx_analogreset));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task req_b(input logic r, input logic w, input logic [2:0] m);
    @(posedge clk_sys);
    lnk_b.mode_sel <= m;
    lnk_b.read <= r;
    lnk_b.write_all <= w;
    @(posedge clk_sys);
    lnk_b.read <= 1'b0;
    lnk_b.write_all <= 1'b0;
    #1;
  endtask
  task err_tail();
    chk("busy", 0, lnk_b.busy);
    chk("error", 1, lnk_b.error);
    @(posedge clk_sys);
    #1 chk("error", 1, lnk_b.error);
    @(posedge clk_sys);
    #1 chk("error", 0, lnk_b.error);
  endtask
  task t_bad(input logic r, input logic w, input logic [2:0] m);
    req_b(r, w, m);
    err_tail();
    $display("illegal request test done");
  endtask
  task t_ok();
    req_b(1'b0, 1'b1, TRCFG_MODE_CHAN);
    chk("busy", 1, lnk_b.busy);
    repeat (20) begin
      @(posedge clk_sys);
      #1;
      if (lnk_b.op_done === 1'b1) break;
    end
    chk("op_done", 1, lnk_b.op_done);
    chk("error", 0, lnk_b.error);
    $display("legal request test done");
  endtask
  task t_timeout();
    stall <= 1'b1;
    req_b(1'b0, 1'b1, TRCFG_MODE_CHAN);
    repeat (100) begin
      @(posedge clk_sys);
      #1;
      if (lnk_b.error === 1'b1) break;
    end
    stall <= 1'b0;
    chk("timeout", 1, lnk_b.error);
    @(posedge clk_sys);
    #1 chk("error", 1, lnk_b.error);
    @(posedge clk_sys);
    #1 chk("error", 0, lnk_b.error);
    $display("timeout test done");
  endtask
  task t_regs();
    rd_reg(TRCFG_OFF_NCHAN);
    chk("nchan", 32'h1, d);
    rd_reg(4'hF);
    chk("unmapped", 32'h0, d);
    wr_reg(TRCFG_OFF_IRQ_EN, 32'h3);
    rd_reg(TRCFG_OFF_IRQ_EN);
    chk("irq_en", 32'h3, d);
    $display("register test done");
  endtask
  task t_freeze();
    req_b(1'b0, 1'b1, TRCFG_MODE_CHAN);
    @(posedge clk_sys);
    ce <= 1'b0;
    repeat (6) @(posedge clk_sys);
    ce <= 1'b1;
    #1 chk("frozen_busy", 1, lnk_b.busy);
    chk("frozen_done", 0, lnk_b.op_done);
    n = 0;
    repeat (20) begin
      @(posedge clk_sys);
      #1 n++;
      if (lnk_b.op_done === 1'b1) break;
    end
    chk("freeze_len", TRCFG_OP_CYC - 1, n);
    $display("clock enable test done");
  endtask
  task t_seq();
    wr_reg(TRCFG_OFF_NCHAN, 32'h2);
    wr_reg(TRCFG_OFF_CTRL, 32'h1);
    repeat (4) @(posedge clk_sys);
    #1 chk("tx_rst", 1, lnk_a.tx_digitalreset);
    chk("rxa_rst", 1, lnk_a.rx_analogreset);
    chk("rxd_rst", 1, lnk_a.rx_digitalreset);
    chk("early_write", 0, lnk_a.write_all);
    chk("irq", 0, irq);
    @(posedge clk_sys);
    lnk_a.pll_reconfig_done <= 1'b1;
    @(posedge clk_sys);
    lnk_a.pll_reconfig_done <= 1'b0;
    n = 0;
    repeat (60) begin
      #1;
      if (lnk_a.write_all === 1'b1) n++;
      if (lnk_a.rx_analogreset === 1'b0) break;
      @(posedge clk_sys);
    end
    chk("chan_writes", 2, n);
    chk("tx_rst_off", 0, lnk_a.tx_digitalreset);
    chk("rxd_held", 1, lnk_a.rx_digitalreset);
    @(posedge clk_sys);
    lnk_a.rx_freqlocked <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge clk_sys);
      #1 n++;
      if (lnk_a.rx_digitalreset === 1'b0) break;
    end
    chk("lock_wait", TB_LOCK_CYC + 1, n);
    @(posedge clk_sys);
    #1 chk("irq_done", 1, irq);
    rd_reg(TRCFG_OFF_IRQ_STAT);
    chk("irq_stat", 32'h1, d);
    wr_reg(TRCFG_OFF_IRQ_CLR, 32'h3);
    rd_reg(TRCFG_OFF_IRQ_STAT);
    chk("irq_clr", 32'h0, d);
    $display("reset sequence test done");
  endtask
  task print_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    {wr, rd, stall, addr, wdata} = '0;
    ce = 1'b1;
    {lnk_a.rx_freqlocked, lnk_a.pll_reconfig_done} = '0;
    {lnk_b.read, lnk_b.write_all, lnk_b.mode_sel, lnk_b.powerdown} = '0;
    {lnk_b.rx_freqlocked, lnk_b.pll_reconfig_done} = '0;
    {lnk_b.tx_digitalreset, lnk_b.rx_digitalreset} = '0;
    lnk_b.rx_analogreset = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (24) @(posedge clk_sys);
    #1 chk("oc_done", 0, lnk_b.offset_cancel);
    t_bad(1'b1, 1'b0, TRCFG_MODE_CHAN);
    t_bad(1'b1, 1'b0, TRCFG_MODE_PMA);
    t_bad(1'b0, 1'b1, TRCFG_MODE_PMA);
    t_ok();
    t_timeout();
    t_freeze();
    t_regs();
    t_seq();
    print_verdict();
  end
  initial begin
    #100us;
    num_errors++;
    print_verdict();
  end
endmodule
